// ===== inc/pcw_pkg.sv
/*
  Package for the power, clock and wake control block: control register
  addresses, reset values, field positions and mode encodings.
  Assumes firmware reaches the registers through the core's control-register
  read/write instructions at the addresses below.
*/
package pcw_pkg;

  // ==========================================================
  // control register addresses
  localparam logic [3:0] ADDR_OPMODE = 4'ha; // operation_mode_control
  localparam logic [3:0] ADDR_P9PU   = 4'hd; // port9_pullup_disable
  localparam logic [3:0] ADDR_SFC    = 4'he; // special_function_control
  localparam logic [3:0] ADDR_IMASK  = 4'hf; // interrupt_enable_mask

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_OPMODE = 8'hc0;
  localparam logic [7:0] RST_P9PU   = 8'hff;
  localparam logic [7:0] RST_SFC    = 8'hd7;
  localparam logic [7:0] RST_IMASK  = 8'h00;
  localparam logic [7:0] P9PU_FIXED = 8'h90; // bits 7 and 4 read one

  // ==========================================================
  // special_function_control fields
  localparam int SFC_PU_LO    = 0; // portgroup a/b/c pullup off, 3 bits
  localparam int SFC_DEVRES   = 3;
  localparam int SFC_RUN      = 4;
  localparam int SFC_WDTEN    = 5;
  localparam int SFC_WAKEN_N  = 6;
  localparam int SFC_NORMCLK  = 7;

  // ==========================================================
  // operation_mode_control fields
  localparam int OPM_MODE_LO = 0;
  localparam int OPM_PDA     = 2;
  localparam int OPM_EXTSEL  = 3;
  localparam int OPM_FRQ_LO  = 6;

  // ==========================================================
  // interrupt source positions
  localparam int IRQ_TIMER   = 0;
  localparam int IRQ_CTLEP   = 1;
  localparam int IRQ_SUSPEND = 2;
  localparam int IRQ_BUSRST  = 3;
  localparam int IRQ_PORT7   = 4;
  localparam int IRQ_PATA    = 5;
  localparam int IRQ_PATB    = 6;
  localparam int IRQ_HOSTRES = 7;

  // ==========================================================
  // watchdog
  localparam int         WDT_W     = 16;
  localparam logic [15:0] WDT_LIMIT = 16'hffff;

  typedef enum logic [1:0] {
    MODE_DETECT = 2'b00,
    MODE_USB    = 2'b01,
    MODE_PS2    = 2'b10,
    MODE_TEST   = 2'b11
  } pcw_mode_e;

  typedef enum logic [1:0] {
    SLOW_500HZ = 2'b00,
    SLOW_4KHZ  = 2'b01,
    SLOW_32KHZ = 2'b10,
    SLOW_256K  = 2'b11
  } pcw_slow_e;

  // firmware control-register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } pcw_ctl_req_s;

  // pull resistor enables, active high
  typedef struct packed {
    logic [7:0] port9;   // bits 7 and 4 never enabled
    logic [2:0] groups;  // port groups a, b, c
    logic       usbWeak; // both data pins, detect mode
    logic       usbDm;   // full pull-up on D-
    logic       ps2;     // both ps/2 pins
  } pcw_pull_s;

endpackage

// ===== design/pcw_ctrl.sv
/*
  Power, clock and wake control: run/sleep, dual clock, wake-up, reset
  sources, pull-up enables, interrupt mask and global gate.
  Assumes the core issues control-register accesses and global irq
  instructions on sys_clk, and that usb controller events are on sys_clk.
*/
// Summary of operation
// - port 9 pull-up register, zero enables
// - low three bits gate group pull-ups
// - resume bit drives resume, cleared off-idle
// - run clear sleeps, wake fall restarts
// - watchdog counts only while enabled
// - active-low wake enable, controller may set
// - dual-clock clear selects slow oscillator
// - slow clock rate from two-bit field
// - field codes four rates, resets high
// - eight mask bits, one enables
// - global disable blocks every interrupt vector
// - flags set even when masked
// - host resume irq only in slow mode
// - mode field resets to detect mode
// - usb pulls D-, ps/2 pulls both
// - usb test mode applies no pull-ups
// - ps/2 mode port 7 changes interrupt
// - power-on loads all initial values
// - low voltage asserts reset
// - watchdog resets core, controller untouched
// - wake on resume, watchdog, port change
// - resume wake sets resume status flag
`timescale 1ns/1ps
module pcw_ctrl
  import pcw_pkg::*;
#(
  parameter logic [15:0] WDT_TOP = WDT_LIMIT
) (
  input  wire logic         sys_clk,      // 200 MHz system clock
  input  wire logic         rst_b,        // power-on reset, async
  input  wire pcw_ctl_req_s ctlReq,       // control register access
  input  wire logic         irqOffInstr,  // global irq disable instr
  input  wire logic         irqOnInstr,   // global irq enable instr
  input  wire logic         wdtClear,     // watchdog clear instr
  input  wire logic [7:0]   irqEvent,     // source events, one-cycle
  input  wire logic [7:0]   flagClear,    // firmware clears flags
  input  wire logic         resWakeClear, // clear resume wake status
  input  wire logic         busNotIdle,   // usb bus not idle
  input  wire logic         hostResume,   // controller resume detect
  input  wire logic         ctrlWakeOff,  // controller sets wake off
  input  wire logic         portWake,     // enabled port change
  input  wire logic [3:0]   port7Pins,    // pins 4..7, async
  input  wire logic         lvdLow,       // regulator below limit
  output logic [7:0]        ctlRdData,    // register read data
  output logic [7:0]        irqFlags,     // interrupt status flags
  output logic              irqVector,    // core jumps to vector
  output logic              coreRun,      // core clock running
  output logic              coreRst_b,    // core reset, low active
  output logic              slowClk,      // core on slow oscillator
  output pcw_slow_e         slowRate,     // slow clock rate
  output logic              extOscOn,     // external osc enabled
  output logic              ctrlRun,      // usb controller enabled
  output logic              devResume,    // drive resume signalling
  output logic              wdtRunning,   // watchdog counting
  output logic              resWake,      // resume wake status
  output logic              extRegSel,    // extra register bank
  output logic              pdaEnable,    // pattern detect enable
  output pcw_pull_s         pull          // pull resistor enables
);

  // ==========================================================
  // synchronisers for pins
  // pins reset low; the ps/2 mode gate hides any false change seen
  // while the synchronisers fill after reset
  logic [3:0] p7Meta, p7Sync, p7Last;
  logic [1:0] lvdSh;
  logic       lvdSync;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      p7Meta <= 4'h0;
      p7Sync <= 4'h0;
      p7Last <= 4'h0;
      lvdSh  <= 2'h0;
    end else begin
      p7Meta <= port7Pins;
      p7Sync <= p7Meta;
      p7Last <= p7Sync;
      lvdSh  <= {lvdSh[0], lvdLow};
    end
  end
  assign lvdSync = lvdSh[1];

  // ==========================================================
  // registers
  logic [7:0] opMode, p9Pu, sfc, iMask;
  logic [7:0] next_opMode, next_p9Pu, next_sfc, next_iMask;
  logic [7:0] flags, next_flags;
  logic       irqOff, next_irqOff;
  logic       resWakeR, next_resWakeR;
  logic [WDT_W-1:0] wdtCnt, next_wdtCnt;
  logic       wakeLine, next_wakeLine;

  // reserved mode bits 5:4 are stored but drive nothing
  wire pcw_mode_e mode = pcw_mode_e'(opMode[OPM_MODE_LO +: 2]);
  wire wrOp   = ctlReq.wr && ctlReq.addr == ADDR_OPMODE;
  wire wrP9   = ctlReq.wr && ctlReq.addr == ADDR_P9PU;
  wire wrSfc  = ctlReq.wr && ctlReq.addr == ADDR_SFC;
  wire wrMask = ctlReq.wr && ctlReq.addr == ADDR_IMASK;

  wire runBit  = sfc[SFC_RUN];
  wire slowOn  = ~sfc[SFC_NORMCLK];
  wire wdtEn   = sfc[SFC_WDTEN];
  wire wdtOvf  = wdtEn && wdtCnt == WDT_TOP;

  // a watchdog overflow also ends sleep, since it restarts the core
  // sleep wake sources; high while any source is present
  wire wakeSrc = (hostResume && !runBit)
               | wdtOvf
               | (portWake && !sfc[SFC_WAKEN_N]);
  // the line idles high and falls when a source appears
  assign next_wakeLine = ~wakeSrc;
  wire wakeFall = wakeLine && !next_wakeLine;
  // a port change still held when run is cleared gives no new fall, so
  // it cannot wake the core until it has dropped once

  // port 7 change only counts in ps/2 mode
  wire p7Change = (mode == MODE_PS2) && (p7Sync != p7Last);

  // ==========================================================
  // next-state logic
  always_comb begin
    next_opMode = wrOp ? ctlReq.data : opMode;
    next_p9Pu   = wrP9 ? (ctlReq.data | P9PU_FIXED) : p9Pu;
    next_iMask  = wrMask ? ctlReq.data : iMask;
    next_sfc    = wrSfc ? ctlReq.data : sfc;
    // hardware clears resume while the bus is busy
    if (busNotIdle)
      next_sfc[SFC_DEVRES] = 1'b0;
    if (ctrlWakeOff)
      next_sfc[SFC_WAKEN_N] = 1'b1;
    // wake restarts the clock and wins over a firmware clear
    if (wakeFall)
      next_sfc[SFC_RUN] = 1'b1;
  end

  // port 7 flag comes from the pins; host resume only on slow clock
  logic [7:0] flagSet;
  always_comb begin
    flagSet              = irqEvent;
    flagSet[IRQ_PORT7]   = p7Change;
    flagSet[IRQ_HOSTRES] = irqEvent[IRQ_HOSTRES]
                           && slowOn && runBit;
  end

  // set wins over firmware clear; masks do not gate flags
  for (genvar g = 0; g < 8; g++) begin : gFlag
    assign next_flags[g] = flagSet[g]
                         | (flags[g] & ~flagClear[g]);
  end

  // reset leaves interrupts globally off until the first enable
  always_comb begin
    next_irqOff = irqOff;
    if (irqOnInstr)
      next_irqOff = 1'b0;
    if (irqOffInstr)
      next_irqOff = 1'b1;
  end

  // resume that ends sleep raises the status flag
  assign next_resWakeR = (hostResume && !runBit)
                       | (resWakeR && !resWakeClear);

  // a disabled count holds, so enabling again resumes from there
  always_comb begin
    next_wdtCnt = wdtCnt;
    if (!wdtEn)
      next_wdtCnt = wdtCnt;
    else if (wdtClear || wdtOvf)
      next_wdtCnt = '0;
    else
      next_wdtCnt = wdtCnt + 1'b1;
  end

  // ==========================================================
  // state registers; low voltage reloads every initial value
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      opMode   <= RST_OPMODE;
      p9Pu     <= RST_P9PU;
      sfc      <= RST_SFC;
      iMask    <= RST_IMASK;
      flags    <= 8'h00;
      irqOff   <= 1'b1;
      resWakeR <= 1'b0;
      wdtCnt   <= '0;
      wakeLine <= 1'b1;
    end else if (lvdSync) begin
      opMode   <= RST_OPMODE;
      p9Pu     <= RST_P9PU;
      sfc      <= RST_SFC;
      iMask    <= RST_IMASK;
      flags    <= 8'h00;
      irqOff   <= 1'b1;
      resWakeR <= 1'b0;
      wdtCnt   <= '0;
      wakeLine <= 1'b1;
    end else begin
      opMode   <= next_opMode;
      p9Pu     <= next_p9Pu;
      sfc      <= next_sfc;
      iMask    <= next_iMask;
      flags    <= next_flags;
      irqOff   <= next_irqOff;
      resWakeR <= next_resWakeR;
      wdtCnt   <= next_wdtCnt;
      wakeLine <= next_wakeLine;
    end
  end

  // ==========================================================
  // read mux, unmapped addresses read zero
  logic [7:0] rdMux;
  always_comb begin
    case (ctlReq.addr)
      ADDR_OPMODE: rdMux = opMode;
      ADDR_P9PU:   rdMux = p9Pu;
      ADDR_SFC:    rdMux = sfc;
      ADDR_IMASK:  rdMux = iMask;
      default:     rdMux = 8'h00;
    endcase
  end

  // ==========================================================
  // pull-up decode
  pcw_pull_s pullNext;
  always_comb begin
    pullNext         = '0;
    pullNext.port9   = ~p9Pu;
    pullNext.groups  = ~sfc[SFC_PU_LO +: 3];
    // test mode leaves both data pins unloaded; D- then needs an
    // external pull-up
    case (mode)
      MODE_DETECT: pullNext.usbWeak = 1'b1;
      MODE_USB:    pullNext.usbDm   = 1'b1;
      MODE_PS2:    pullNext.ps2     = 1'b1;
      MODE_TEST:   pullNext.usbDm   = 1'b0;
      default:     pullNext.usbDm   = 1'b0;
    endcase
  end

  // global gate suppresses only the vector jump
  // the vector is a level; it drops once firmware clears the flag
  wire irqNext = |(flags & iMask) && !irqOff;

  // watchdog reset hits the core only; usb controller is kept
  // low voltage holds the core one cycle past the register reload
  wire rstNext = !(wdtOvf || lvdSync);

  // ==========================================================
  // registered outputs
  // slow clock parks the external oscillator and the usb controller;
  // read data is taken on the read strobe and holds until the next
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctlRdData  <= 8'h00;
      irqFlags   <= 8'h00;
      irqVector  <= 1'b0;
      coreRun    <= 1'b1;
      coreRst_b  <= 1'b0;
      slowClk    <= 1'b0;
      slowRate   <= SLOW_256K;
      extOscOn   <= 1'b1;
      ctrlRun    <= 1'b1;
      devResume  <= 1'b0;
      wdtRunning <= 1'b0;
      resWake    <= 1'b0;
      extRegSel  <= 1'b0;
      pdaEnable  <= 1'b0;
      pull       <= '0;
    end else begin
      ctlRdData  <= ctlReq.rd ? rdMux : ctlRdData;
      irqFlags   <= flags;
      irqVector  <= irqNext;
      coreRun    <= runBit;
      coreRst_b  <= rstNext;
      slowClk    <= slowOn;
      slowRate   <= pcw_slow_e'(opMode[OPM_FRQ_LO +: 2]);
      extOscOn   <= !slowOn && runBit;
      ctrlRun    <= !slowOn;
      devResume  <= sfc[SFC_DEVRES];
      wdtRunning <= wdtEn;
      resWake    <= resWakeR;
      extRegSel  <= opMode[OPM_EXTSEL];
      pdaEnable  <= opMode[OPM_PDA];
      pull       <= pullNext;
    end
  end

endmodule

// ===== verif/pcw_ctrl_assertions.sv
/*
  Port checker for the power, clock and wake control block.
  Assumes sys_clk clocks every port and rst_b is the only reset.
*/
`timescale 1ns/1ps
module pcw_ctrl_checker
  import pcw_pkg::*;
#(
  parameter logic [15:0] WDT_TOP = WDT_LIMIT
) (
  input wire logic      sys_clk,    // clock
  input wire logic      rst_b,      // reset, low active
  input wire logic      irqOffInstr, // global disable
  input wire logic      irqOnInstr, // global enable
  input wire logic      busNotIdle, // bus left idle
  input wire logic      hostResume, // resume detect
  input wire logic      lvdLow,     // low voltage
  input wire logic [7:0] irqFlags,  // status flags
  input wire logic      irqVector,  // vector request
  input wire logic      coreRun,    // run bit
  input wire logic      coreRst_b,  // core reset
  input wire logic      slowClk,    // slow clock
  input wire logic      extOscOn,   // external osc
  input wire logic      ctrlRun,    // controller on
  input wire logic      devResume,  // resume drive
  input wire logic      resWake,    // resume wake flag
  input wire pcw_pull_s pull        // pull enables
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // properties
  sequence s_sleepResume;
    !coreRun && hostResume;
  endsequence
  property p_p9Fixed;
    !pull.port9[7] && !pull.port9[4];
  endproperty
  a_p9Fixed: assert property (p_p9Fixed)
    else $error("port 9 fixed bit enabled");
  property p_slowCtrl;
    slowClk |-> !ctrlRun;
  endproperty
  a_slowCtrl: assert property (p_slowCtrl)
    else $error("controller runs on slow clock");
  property p_oscOff;
    extOscOn |-> coreRun && !slowClk;
  endproperty
  a_oscOff: assert property (p_oscOff)
    else $error("oscillator on in sleep or slow mode");
  property p_irqOff;
    irqOffInstr ##1 !irqOnInstr |=> ##1 !irqVector;
  endproperty
  a_irqOff: assert property (p_irqOff)
    else $error("vector after global disable");
  property p_vecFlag;
    irqVector |-> irqFlags != 8'h00;
  endproperty
  a_vecFlag: assert property (p_vecFlag)
    else $error("vector with no flag");
  property p_resClr;
    busNotIdle |-> ##2 !devResume;
  endproperty
  a_resClr: assert property (p_resClr)
    else $error("resume drive kept off idle");
  property p_wdtPulse;
    $fell(coreRst_b) && !$past(lvdLow, 2) && !$past(lvdLow, 3)
      |=> coreRst_b;
  endproperty
  a_wdtPulse: assert property (p_wdtPulse)
    else $error("watchdog reset longer than one cycle");
  property p_wake;
    s_sleepResume |-> ##[1:4] coreRun;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on resume");
  property p_resWake;
    s_sleepResume |-> ##[1:4] resWake;
  endproperty
  a_resWake: assert property (p_resWake)
    else $error("resume wake flag not set");
  property p_usbPull;
    pull.usbDm |-> !pull.ps2 && !pull.usbWeak;
  endproperty
  a_usbPull: assert property (p_usbPull)
    else $error("mixed pull-ups in usb mode");
endmodule

bind pcw_ctrl pcw_ctrl_checker #(.WDT_TOP(WDT_TOP)) chk_i (.sys_clk,
  .rst_b, .irqOffInstr, .irqOnInstr, .busNotIdle, .hostResume, .lvdLow,
  .irqFlags, .irqVector, .coreRun, .coreRst_b, .slowClk, .extOscOn,
  .ctrlRun, .devResume, .resWake, .pull);

// ===== verif/pcw_ctrl_bench.sv
/*
  Self-checking bench for the power, clock and wake control block.
  Assumes the port checker is bound in; single-bit strobes share one vector.
*/
`timescale 1ns/1ps
module pcw_ctrl_bench;
  import pcw_pkg::*;
  logic         sys_clk, rst_b, irqVector, coreRun, coreRst_b, slowClk;
  logic         extOscOn, ctrlRun, devResume, wdtRunning, resWake;
  logic         extRegSel, pdaEnable;
  logic         irqOffInstr, irqOnInstr, wdtClear, resWakeClear, busNotIdle;
  logic         hostResume, ctrlWakeOff, portWake, lvdLow;
  logic [7:0]   irqEvent, flagClear, ctlRdData, irqFlags;
  logic [3:0]   port7Pins;
  logic [24:0]  pl;
  pcw_ctl_req_s ctlReq;
  pcw_slow_e    slowRate;
  pcw_pull_s    pull;
  int           n_fail, n_checks, nRst, i;

  assign {flagClear, irqEvent, irqOffInstr, irqOnInstr, wdtClear,
    resWakeClear, busNotIdle, hostResume, ctrlWakeOff, portWake,
    lvdLow} = pl;

  pcw_ctrl #(.WDT_TOP(16'h20)) pcw_ctrl_i (.sys_clk, .rst_b, .ctlReq,
    .irqOffInstr, .irqOnInstr, .wdtClear, .irqEvent, .flagClear,
    .resWakeClear, .busNotIdle, .hostResume, .ctrlWakeOff, .portWake,
    .port7Pins, .lvdLow,
    .ctlRdData, .irqFlags, .irqVector, .coreRun, .coreRst_b, .slowClk,
    .slowRate, .extOscOn, .ctrlRun, .devResume, .wdtRunning, .resWake,
    .extRegSel, .pdaEnable, .pull);

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rst_b && !coreRst_b) nRst++;

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) ctlReq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) ctlReq <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk) ctlReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) ctlReq <= '0;
    #1 chk("rdData", exp, ctlRdData);
  endtask
  // strobes are held n cycles then dropped together
  task automatic pulse(input logic [24:0] m, input int n);
    @(posedge sys_clk) pl <= m;
    repeat (n) @(posedge sys_clk);
    pl <= '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog on the whole run
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    {sys_clk, rst_b, ctlReq, pl, port7Pins, n_fail, n_checks, nRst} = '0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ADDR_OPMODE, 8'hc0);
    rd(ADDR_P9PU, 8'hff);
    rd(ADDR_SFC, 8'hd7);
    rd(ADDR_IMASK, 8'h00);
    rd(4'h0, 8'h00);
    $display("reset values done");
    wr(ADDR_P9PU, 8'h00);
    rd(ADDR_P9PU, 8'h90);
    wr(ADDR_SFC, 8'hd2);
    wt(2);
    chk("port9", 8'h6f, pull.port9);
    chk("groups", 8'h05, {5'b0, pull.groups});
    for (i = 0; i < 4; i++) begin
      wr(ADDR_OPMODE, {i[1:0], 2'b00, i[1:0], i[1:0]});
      wt(2);
      chk("rate", 8'(i), 8'(slowRate));
      chk("modePull", {5'b0, i == 0, i == 1, i == 2},
        {5'b0, pull.usbWeak, pull.usbDm, pull.ps2});
      chk("bank", 8'(i), {6'b0, extRegSel, pdaEnable});
    end
    $display("pulls and modes done");
    wr(ADDR_IMASK, 8'h80);
    pulse(25'h80, 1);
    wr(ADDR_SFC, 8'h52);
    wt(2);
    chk("clocks", 8'h04, {5'b0, slowClk, extOscOn, ctrlRun});
    pulse(25'h10000, 1);
    wt(3);
    chk("hostRes", 8'h80, irqFlags);
    chk("vector", 8'h01, 8'(irqVector));
    wr(ADDR_SFC, 8'hd2);
    pulse(25'h1fe0000, 1);
    pulse(25'h10000, 1);
    wt(3);
    chk("hostRes", 8'h00, irqFlags);
    wr(ADDR_IMASK, 8'h00);
    pulse(25'h200, 1);
    wt(3);
    chk("masked", 8'h02, {irqFlags[6:0], irqVector});
    wr(ADDR_IMASK, 8'h01);
    wt(3);
    chk("vector", 8'h01, 8'(irqVector));
    pulse(25'h100, 1);
    wt(3);
    chk("vector", 8'h00, 8'(irqVector));
    pulse(25'h80, 1);
    wt(3);
    chk("vector", 8'h01, 8'(irqVector));
    $display("interrupts done");
    wr(ADDR_SFC, 8'hda);
    wt(2);
    chk("resume", 8'h01, 8'(devResume));
    pulse(25'h10, 1);
    rd(ADDR_SFC, 8'hd2);
    wr(ADDR_SFC, 8'hc2);
    wt(2);
    chk("sleep", 8'h00, {6'b0, coreRun, extOscOn});
    pulse(25'h8, 1);
    wt(4);
    chk("wake", 8'h03, {6'b0, coreRun, resWake});
    pulse(25'h20, 1);
    wr(ADDR_SFC, 8'h82);
    wt(2);
    pulse(25'h2, 1);
    wt(4);
    chk("portWake", 8'h02, {6'b0, coreRun, resWake});
    pulse(25'h4, 1);
    rd(ADDR_SFC, 8'hd2);
    $display("sleep and wake done");
    wr(ADDR_SFC, 8'hf2);
    wt(2);
    chk("wdtRun", 8'h01, 8'(wdtRunning));
    nRst = 0;
    wt(80);
    chk("wdtRst", 8'h02, 8'(nRst));
    rd(ADDR_SFC, 8'hf2);
    wr(ADDR_SFC, 8'hd2);
    wt(2);
    chk("wdtRun", 8'h00, 8'(wdtRunning));
    nRst = 0;
    wt(80);
    chk("wdtOff", 8'h00, 8'(nRst));
    wr(ADDR_IMASK, 8'h55);
    pulse(25'h1, 6);
    wt(8);
    chk("lvdRst", 8'h01, 8'(nRst != 0));
    rd(ADDR_IMASK, 8'h00);
    rd(ADDR_SFC, 8'hd7);
    $display("reset sources done");
    @(posedge sys_clk) port7Pins <= 4'h3;
    wt(6);
    chk("p7Detect", 8'h00, irqFlags);
    wr(ADDR_OPMODE, 8'hc2);
    @(posedge sys_clk) port7Pins <= 4'h5;
    wt(6);
    chk("p7Ps2", 8'h10, irqFlags);
    $display("port 7 change done");
    give_verdict();
  end
endmodule
